// ===== bench/fsio_link_chk.sv
// Checker of the handshakes on the image link between the master and slave ends.
`timescale 1ns/1ps
`include "fsio_defines.svh"
module fsio_link_chk (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic prm_valid,
  input wire logic [3:0] prm_index,
  input wire logic [7:0] prm_data,
  input wire logic prm_end,
  input wire logic prm_ack,
  input wire logic prm_fault,
  input wire logic cfg_valid,
  input wire logic dx_req,
  input wire logic dx_ack,
  input wire logic [95:0] dx_in
);
  localparam int CYC = `FSIO_CYCLE_CNT;
  logic [1:0] order; // Order bits of the last byte ten offered.
  logic cfg_seen; // Configuration given since the last parameter block.
  logic had_req; // One exchange request has already been seen.
  int gap; // Cycles since the last exchange request.

  //////////////////////////////////////////////////////////////////////////////
  // Helper state follows the link so that spacing and order can be judged.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      order <= 2'h0;
      cfg_seen <= 1'b0;
      had_req <= 1'b0;
      gap <= 0;
    end else begin
      if (prm_valid && prm_index == 4'hA) begin
        order <= prm_data[1:0];
      end
      // A new parameter block restarts the startup, so the gates close again.
      cfg_seen <= prm_end ? 1'b0 : (cfg_seen | cfg_valid);
      had_req <= prm_end ? 1'b0 : (had_req | dx_req);
      gap <= dx_req ? 0 : gap + 1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  // A verdict and an exchange answer are both single-cycle pulses one cycle late.
  sequence s_verdict;
    ##1 prm_ack ##1 !prm_ack;
  endsequence
  sequence s_answer;
    ##1 dx_ack ##1 !dx_ack;
  endsequence

  property p_verdict;
    prm_end |-> s_verdict;
  endproperty
  a_verdict: assert property (p_verdict) else $error("parameter verdict not one cycle after block end");
  property p_fault;
    prm_end |=> (prm_fault == (order == 2'h0 || order == 2'h3));
  endproperty
  a_fault: assert property (p_fault) else $error("refusal does not match order bits");
  property p_index;
    prm_valid |-> (prm_index >= 4'h1 && prm_index <= 4'hB);
  endproperty
  a_index: assert property (p_index) else $error("parameter byte number out of range");
  // The master registers the verdict on one edge and launches the configuration on the next.
  property p_cfg;
    cfg_valid |-> $past(prm_ack, 2) && !prm_fault;
  endproperty
  a_cfg: assert property (p_cfg) else $error("configuration without good verdict");
  property p_gate;
    dx_req |-> cfg_seen;
  endproperty
  a_gate: assert property (p_gate) else $error("exchange before configuration");
  property p_answer;
    dx_req |-> s_answer;
  endproperty
  a_answer: assert property (p_answer) else $error("exchange not answered in one cycle");
  property p_cause;
    dx_ack |-> $past(dx_req);
  endproperty
  a_cause: assert property (p_cause) else $error("answer without request");
  property p_hold;
    !dx_ack |-> $stable(dx_in);
  endproperty
  a_hold: assert property (p_hold) else $error("input image changed between answers");
  property p_gap;
    dx_req && had_req |-> gap == CYC - 1;
  endproperty
  a_gap: assert property (p_gap) else $error("exchange period wrong");
endmodule

// ===== bench/test_fieldbus_slave_io_image.sv
// Self-checking bench joining the master and slave ends across the image link.
`timescale 1ns/1ps
module test_fieldbus_slave_io_image;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic start_i = 1'b0;
  logic a_valid = 1'b0;
  logic [1:0] byte_order_i = 2'h0;
  logic [15:0] m_cw1 = 16'h0, m_cw2 = 16'h0, s_sw1 = 16'h0, s_sw2 = 16'h0, pc_idx = 16'h0;
  logic [3:0] pc_code = 4'h0, a_code = 4'h0;
  logic [11:0] pc_num = 12'h0;
  logic [31:0] pc_val = 32'h0, a_val = 32'h0;
  logic [15:0] s_cw1, s_cw2, m_sw1, m_sw2, s_ridx;
  logic [3:0] s_set, s_rcode, m_acode;
  logic [11:0] s_rnum, m_anum;
  logic [31:0] s_rval, m_aval;
  logic s_weld, s_horn, s_reqv, s_act, s_err, s_le, m_done, m_run, m_err;
  logic [95:0] wire_out; // Output image as it crossed the link.
  logic wseen, hseen, rseen; // Pulses caught during one exchange.
  int n_errors = 0, checked = 0, cycles = 0, acks;

  fsio_link_if fsio_link_if_inst();
  fsio_slave fsio_slave_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .link(fsio_link_if_inst.slave_mp),
    .status_word_one_i(s_sw1), .status_word_two_i(s_sw2), .ans_valid_i(a_valid), .ans_code_i(a_code),
    .ans_value_i(a_val), .control_word_one_o(s_cw1), .control_word_two_o(s_cw2), .parset_sel_o(s_set),
    .weld_trigger_o(s_weld), .horn_trigger_o(s_horn), .req_valid_o(s_reqv), .req_code_o(s_rcode),
    .req_number_o(s_rnum), .req_index_o(s_ridx), .req_value_o(s_rval), .exchange_active_o(s_act),
    .prm_error_o(s_err), .little_endian_o(s_le));
  fsio_master fsio_master_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .link(fsio_link_if_inst.master_mp),
    .start_i(start_i), .byte_order_i(byte_order_i), .control_word_one_i(m_cw1), .control_word_two_i(m_cw2),
    .pc_code_i(pc_code), .pc_number_i(pc_num), .pc_index_i(pc_idx), .pc_value_i(pc_val),
    .status_word_one_o(m_sw1), .status_word_two_o(m_sw2), .ans_code_o(m_acode), .ans_number_o(m_anum),
    .ans_value_o(m_aval), .cycle_done_o(m_done), .running_o(m_run), .prm_error_o(m_err));
  fsio_link_chk fsio_link_chk_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .prm_valid(fsio_link_if_inst.prm_valid), .prm_index(fsio_link_if_inst.prm_index),
    .prm_data(fsio_link_if_inst.prm_data), .prm_end(fsio_link_if_inst.prm_end),
    .prm_ack(fsio_link_if_inst.prm_ack), .prm_fault(fsio_link_if_inst.prm_fault),
    .cfg_valid(fsio_link_if_inst.cfg_valid), .dx_req(fsio_link_if_inst.dx_req),
    .dx_ack(fsio_link_if_inst.dx_ack), .dx_in(fsio_link_if_inst.dx_in));

  //////////////////////////////////////////////////////////////////////////////
  // Free-running clock at 100 MHz.
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end

  // A hung handshake must not stall the run, so a cycle ceiling closes it.
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 12000) begin
      n_errors++;
      give_verdict();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts the result.
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Resets both ends for four cycles and starts the master with one order value.
  task automatic do_start(input logic [1:0] order);
    @(negedge mclk_i);
    rst_n_i = 1'b0;
    byte_order_i = order;
    repeat (4) @(negedge mclk_i);
    rst_n_i = 1'b1;
    start_i = 1'b1;
    @(negedge mclk_i);
    start_i = 1'b0;
    for (int i = 0; i < 40 && m_run !== 1'b1 && m_err !== 1'b1; i++) @(negedge mclk_i);
    // The slave takes the configuration one edge after the master enters its cyclic phase.
    @(negedge mclk_i);
  endtask

  // Waits for one complete exchange and catches the pulses that it raises.
  task automatic wait_cycle();
    wseen = 1'b0;
    hseen = 1'b0;
    rseen = 1'b0;
    @(negedge mclk_i);
    for (int i = 0; i < 1100 && m_done !== 1'b1; i++) begin
      @(negedge mclk_i);
      if (fsio_link_if_inst.dx_req === 1'b1) wire_out = fsio_link_if_inst.dx_out;
      wseen = wseen | s_weld;
      hseen = hseen | s_horn;
      rseen = rseen | s_reqv;
    end
    chk("cycle done", m_done, 1'h1);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Default and doubly set order bits must both be refused with no exchange after.
  task automatic t_refuse();
    for (int k = 0; k < 2; k++) begin
      do_start(k == 0 ? 2'h0 : 2'h3);
      chk("master error", m_err, 1'h1);
      chk("slave error", s_err, 1'h1);
      chk("link fault", fsio_link_if_inst.prm_fault, 1'h1);
      chk("active", s_act, 1'h0);
      acks = 0;
      for (int i = 0; i < 1100; i++) begin
        @(negedge mclk_i);
        acks += (fsio_link_if_inst.dx_ack === 1'b1) ? 1 : 0;
      end
      chk("answers", acks, 32'h0);
    end
    $display("test refuse done");
  endtask

  // Full startup and two exchanges in one order, with a parameter request answered late.
  task automatic t_run(input logic le);
    do_start(le ? 2'h2 : 2'h1);
    chk("slave error", s_err, 1'h0);
    chk("order", s_le, le);
    chk("active", s_act, 1'h1);
    chk("running", m_run, 1'h1);
    m_cw1 = 16'h0105;
    m_cw2 = 16'hA55A;
    pc_code = 4'h3;
    pc_num = 12'h123;
    pc_idx = 16'h0204;
    pc_val = 32'h11223344;
    s_sw1 = 16'h8001;
    s_sw2 = 16'h7E42;
    wait_cycle();
    chk("control one", s_cw1, 16'h0105);
    chk("control two", s_cw2, 16'hA55A);
    chk("set", s_set, 4'h5);
    chk("weld", wseen, 1'h1);
    chk("horn", hseen, 1'h0);
    chk("req code", s_rcode, 4'h3);
    chk("req number", s_rnum, 12'h123);
    chk("req index", s_ridx, 16'h0204);
    chk("req value", s_rval, 32'h11223344);
    chk("req pulse", rseen, 1'h1);
    chk("wire ident", wire_out[95:80], le ? 16'h2331 : 16'h3123);
    chk("wire index", wire_out[79:64], le ? 16'h0402 : 16'h0204);
    chk("wire value", wire_out[63:32], le ? 32'h44332211 : 32'h11223344);
    chk("wire control", wire_out[31:0], le ? 32'h05015AA5 : 32'h0105A55A);
    chk("status one", m_sw1, 16'h8001);
    chk("status two", m_sw2, 16'h7E42);
    chk("wire status", fsio_link_if_inst.dx_in[31:0], le ? 32'h0180427E : 32'h80017E42);
    chk("answer pending", m_acode, 4'h0);
    a_valid = 1'b1;
    a_code = 4'h3;
    a_val = 32'hCAFE0001;
    @(negedge mclk_i);
    a_valid = 1'b0;
    m_cw1 = 16'h0205;
    wait_cycle();
    chk("answer code", m_acode, 4'h3);
    chk("answer number", m_anum, 12'h123);
    chk("answer value", m_aval, 32'hCAFE0001);
    chk("wire answer", fsio_link_if_inst.dx_in[63:32], le ? 32'h0100FECA : 32'hCAFE0001);
    chk("control again", s_cw1, 16'h0205);
    chk("horn", hseen, 1'h1);
    chk("weld", wseen, 1'h0);
    $display("test run done");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    t_refuse();
    t_run(1'b0);
    t_run(1'b1);
    give_verdict();
  end
endmodule

// ===== design/fsio_defines.svh
// Constants of the cyclic I/O image link: field positions, codes and timing counts.
`ifndef FSIO_DEFINES_SVH
`define FSIO_DEFINES_SVH
`define FSIO_IMAGE_BYTES 12
`define FSIO_IMAGE_BITS 96
`define FSIO_PRM_BYTES 11
`define FSIO_PRM_ORDER_BYTE 4'hA
`define FSIO_ORDER_DEFAULT 2'h0
`define FSIO_ORDER_BIG 2'h1
`define FSIO_ORDER_LITTLE 2'h2
`define FSIO_ID_MSB 95
`define FSIO_IDX_MSB 79
`define FSIO_VAL_MSB 63
`define FSIO_PD1_MSB 31
`define FSIO_PD2_MSB 15
`define FSIO_CODE_MSB 15
`define FSIO_NUM_MSB 11
`define FSIO_CODE_NONE 4'h0
`define FSIO_PARSET_MSB 3
`define FSIO_WELD_BIT 8
`define FSIO_HORN_BIT 9
`define FSIO_CLK_NS 10
`define FSIO_CYCLE_NS 10000
`define FSIO_CYCLE_CNT (`FSIO_CYCLE_NS / `FSIO_CLK_NS)
`endif

// ===== design/fsio_link_if.sv
// Logic-level link between the cyclic master and the I/O image slave.
`timescale 1ns/1ps
interface fsio_link_if;
  logic prm_valid; // One user-parameter byte is offered.
  logic [3:0] prm_index; // Number of that byte, 1 to 11.
  logic [7:0] prm_data; // The byte itself.
  logic prm_end; // The parameter block is complete.
  logic prm_ack; // Slave has judged the block.
  logic prm_fault; // Slave rejected the block.
  logic cfg_valid; // Configuration telegram.
  logic dx_req; // Cyclic exchange request with the output image.
  logic [95:0] dx_out; // Master-to-slave image, byte 0 in the top bits.
  logic dx_ack; // Slave answers with the input image.
  logic [95:0] dx_in; // Slave-to-master image, byte 0 in the top bits.

  modport master_mp (output prm_valid, prm_index, prm_data, prm_end, cfg_valid, dx_req, dx_out,
                     input prm_ack, prm_fault, dx_ack, dx_in);
  modport slave_mp (input prm_valid, prm_index, prm_data, prm_end, cfg_valid, dx_req, dx_out,
                    output prm_ack, prm_fault, dx_ack, dx_in);
endinterface

// ===== design/fsio_master.sv
// Master end: parameterises the slave, configures it and runs the cyclic image exchange.
`timescale 1ns/1ps
module fsio_master
  import fsio_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  fsio_link_if.master_mp link,
  input wire logic start_i,
  input wire logic [1:0] byte_order_i,
  input wire logic [15:0] control_word_one_i,
  input wire logic [15:0] control_word_two_i,
  input wire logic [3:0] pc_code_i,
  input wire logic [11:0] pc_number_i,
  input wire logic [15:0] pc_index_i,
  input wire logic [31:0] pc_value_i,
  output logic [15:0] status_word_one_o,
  output logic [15:0] status_word_two_o,
  output logic [3:0] ans_code_o,
  output logic [11:0] ans_number_o,
  output logic [31:0] ans_value_o,
  output logic cycle_done_o,
  output logic running_o,
  output logic prm_error_o
);
  `include "fsio_defines.svh"

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  fsio_master_state_type state, next_state; // Startup phase.
  logic [3:0] idx, next_idx; // Parameter byte being sent.
  logic [1:0] order, next_order; // Byte order captured at start.
  logic [13:0] tick, next_tick; // Exchange period divider.
  logic busy, next_busy; // An exchange awaits its answer.
  logic prm_valid, next_prm_valid;
  logic prm_end, next_prm_end;
  logic cfg_valid, next_cfg_valid;
  logic dx_req, next_dx_req;
  logic [95:0] dx_out, next_dx_out;
  logic [95:0] img, next_img; // Last input image, wire order.
  logic done, next_done; // Exchange completed pulse.
  logic fault, next_fault; // Slave refused the parameters.
  logic le;
  logic [15:0] ans_id; // Identifier of the last input image, native order.

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // The output image is built from one snapshot of the user inputs so each region is consistent.
  always_comb begin
    next_state = state;
    next_idx = idx;
    next_order = order;
    next_tick = tick;
    next_busy = busy;
    next_prm_valid = 1'b0;
    next_prm_end = 1'b0;
    next_cfg_valid = 1'b0;
    next_dx_req = 1'b0;
    next_dx_out = dx_out;
    next_img = img;
    next_done = 1'b0;
    next_fault = fault;
    le = (order == `FSIO_ORDER_LITTLE);
    case (state)
      MST_IDLE, MST_FAULT: begin
        if (start_i) begin
          next_order = byte_order_i;
          next_idx = 4'h1;
          next_fault = 1'b0;
          next_state = MST_SEND_PRM;
        end
      end
      MST_SEND_PRM: begin
        // Bytes other than byte ten are sent as zero.
        if (idx > 4'(`FSIO_PRM_BYTES)) begin
          next_prm_end = 1'b1;
          next_state = MST_WAIT_PRM;
        end else begin
          next_prm_valid = 1'b1;
          next_idx = idx + 4'h1;
        end
      end
      MST_WAIT_PRM: begin
        if (link.prm_ack) begin
          next_fault = link.prm_fault;
          next_state = link.prm_fault ? MST_FAULT : MST_SEND_CFG;
        end
      end
      MST_SEND_CFG: begin
        next_cfg_valid = 1'b1;
        next_tick = 14'h0;
        next_state = MST_EXCHANGE;
      end
      MST_EXCHANGE: begin
        if (link.dx_ack) begin
          next_busy = 1'b0;
          next_img = link.dx_in;
          next_done = 1'b1;
        end
        if (tick == 14'(`FSIO_CYCLE_CNT - 1)) begin
          next_tick = 14'h0;
          // A slow answer makes this period skip rather than stack requests.
          if (!busy) begin
            next_busy = 1'b1;
            next_dx_req = 1'b1;
            next_dx_out = {fsio_order16({pc_code_i, pc_number_i}, le),
                           fsio_order16(pc_index_i, le),
                           fsio_order32(pc_value_i, le),
                           fsio_order16(control_word_one_i, le),
                           fsio_order16(control_word_two_i, le)};
          end
        end else begin
          next_tick = tick + 14'h1;
        end
      end
      default: begin
        next_state = MST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= MST_IDLE;
      idx <= 4'h0;
      order <= 2'h0;
      tick <= 14'h0;
      busy <= 1'b0;
      prm_valid <= 1'b0;
      prm_end <= 1'b0;
      cfg_valid <= 1'b0;
      dx_req <= 1'b0;
      dx_out <= 96'h0;
      img <= 96'h0;
      done <= 1'b0;
      fault <= 1'b0;
    end else begin
      state <= next_state;
      idx <= next_idx;
      order <= next_order;
      tick <= next_tick;
      busy <= next_busy;
      prm_valid <= next_prm_valid;
      prm_end <= next_prm_end;
      cfg_valid <= next_cfg_valid;
      dx_req <= next_dx_req;
      dx_out <= next_dx_out;
      img <= next_img;
      done <= next_done;
      fault <= next_fault;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs; the index register already points one past the byte on the link.

  assign link.prm_valid = prm_valid;
  assign link.prm_index = idx - 4'h1;
  assign link.prm_data = ((idx - 4'h1) == `FSIO_PRM_ORDER_BYTE) ? {6'h00, order} : 8'h00;
  assign link.prm_end = prm_end;
  assign link.cfg_valid = cfg_valid;
  assign link.dx_req = dx_req;
  assign link.dx_out = dx_out;
  // The identifier is converted once and then split into its code and number fields.
  assign ans_id = fsio_order16(img[`FSIO_ID_MSB -: 16], le);
  assign ans_code_o = ans_id[`FSIO_CODE_MSB -: 4];
  assign ans_number_o = ans_id[`FSIO_NUM_MSB:0];
  assign ans_value_o = fsio_order32(img[`FSIO_VAL_MSB -: 32], le);
  assign status_word_one_o = fsio_order16(img[`FSIO_PD1_MSB -: 16], le);
  assign status_word_two_o = fsio_order16(img[`FSIO_PD2_MSB -: 16], le);
  assign cycle_done_o = done;
  assign running_o = (state == MST_EXCHANGE);
  assign prm_error_o = fault;
endmodule

// ===== design/fsio_pkg.sv
// Types and byte-order helpers shared by both ends of the I/O image link.
package fsio_pkg;
  // Parameterisation phase of the slave; Gray codes along the startup path.
  typedef enum logic [1:0] {
    SLV_WAIT_PRM = 2'h0,
    SLV_WAIT_CFG = 2'h1,
    SLV_EXCHANGE = 2'h3,
    SLV_FAULT = 2'h2
  } fsio_slave_state_type;

  // Startup and cyclic phase of the master; Gray codes along the startup path.
  typedef enum logic [2:0] {
    MST_IDLE = 3'h0,
    MST_SEND_PRM = 3'h1,
    MST_WAIT_PRM = 3'h3,
    MST_SEND_CFG = 3'h2,
    MST_EXCHANGE = 3'h6,
    MST_FAULT = 3'h7
  } fsio_master_state_type;

  // Converts a 16-bit field between wire order and native order; the swap is its own inverse.
  function automatic logic [15:0] fsio_order16(input logic [15:0] w, input logic le);
    fsio_order16 = le ? {w[7:0], w[15:8]} : w;
  endfunction

  // Converts a 32-bit field between wire order and native order.
  function automatic logic [31:0] fsio_order32(input logic [31:0] w, input logic le);
    fsio_order32 = le ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
  endfunction
endpackage

// ===== design/fsio_slave.sv
// Slave end: user parameters, byte order and the 12-byte cyclic I/O image.
`timescale 1ns/1ps
module fsio_slave
  import fsio_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  fsio_link_if.slave_mp link,
  input wire logic [15:0] status_word_one_i,
  input wire logic [15:0] status_word_two_i,
  input wire logic ans_valid_i,
  input wire logic [3:0] ans_code_i,
  input wire logic [31:0] ans_value_i,
  output logic [15:0] control_word_one_o,
  output logic [15:0] control_word_two_o,
  output logic [3:0] parset_sel_o,
  output logic weld_trigger_o,
  output logic horn_trigger_o,
  output logic req_valid_o,
  output logic [3:0] req_code_o,
  output logic [11:0] req_number_o,
  output logic [15:0] req_index_o,
  output logic [31:0] req_value_o,
  output logic exchange_active_o,
  output logic prm_error_o,
  output logic little_endian_o
);
  `include "fsio_defines.svh"

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  fsio_slave_state_type state, next_state; // Startup phase.
  logic [7:0] order_byte, next_order_byte; // Byte ten as last received.
  logic le, next_le; // Applied byte order, set only by a good block.
  logic prm_ack, next_prm_ack; // Verdict pulse to the master.
  logic prm_fault, next_prm_fault; // Verdict level to the master.
  logic dx_ack, next_dx_ack; // Answer pulse of an exchange.
  logic [95:0] dx_in, next_dx_in; // Input image, replaced as one unit.
  logic [15:0] cw1, next_cw1; // Native control word one.
  logic [15:0] cw2, next_cw2; // Native control word two.
  logic weld, next_weld; // Weld trigger pulse.
  logic horn, next_horn; // Horn trigger pulse.
  logic req_valid, next_req_valid; // New parameter-channel request pulse.
  logic [15:0] req_id, next_req_id; // Last identifier seen, native order.
  logic [15:0] req_idx, next_req_idx; // Last index seen, native order.
  logic [31:0] req_val, next_req_val; // Last value seen, native order.
  logic [3:0] ans_code, next_ans_code; // Answer code placed in the input image.
  logic [31:0] ans_val, next_ans_val; // Answer value placed in the input image.

  // Fields of the arriving image, converted with the applied order.
  logic [15:0] in_id;
  logic [15:0] in_idx;
  logic [31:0] in_val;
  logic [15:0] in_cw1;
  logic [15:0] in_cw2;

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // All slave state moves together so that the verdict, the order and the image stay in step.
  always_comb begin
    next_state = state;
    next_order_byte = order_byte;
    next_le = le;
    next_prm_ack = 1'b0;
    next_prm_fault = prm_fault;
    next_dx_ack = 1'b0;
    next_dx_in = dx_in;
    next_cw1 = cw1;
    next_cw2 = cw2;
    next_weld = 1'b0;
    next_horn = 1'b0;
    next_req_valid = 1'b0;
    next_req_id = req_id;
    next_req_idx = req_idx;
    next_req_val = req_val;
    next_ans_code = ans_code;
    next_ans_val = ans_val;
    in_id = fsio_order16(link.dx_out[`FSIO_ID_MSB -: 16], le);
    in_idx = fsio_order16(link.dx_out[`FSIO_IDX_MSB -: 16], le);
    in_val = fsio_order32(link.dx_out[`FSIO_VAL_MSB -: 32], le);
    in_cw1 = fsio_order16(link.dx_out[`FSIO_PD1_MSB -: 16], le);
    in_cw2 = fsio_order16(link.dx_out[`FSIO_PD2_MSB -: 16], le);
    // The user answer may arrive in any cycle; its code stays until a changed request clears it.
    if (ans_valid_i) begin
      next_ans_code = ans_code_i;
      next_ans_val = ans_value_i;
    end
    // A parameter byte is taken in any phase, so a master may re-parameterise.
    if (link.prm_valid) begin
      if (link.prm_index == `FSIO_PRM_ORDER_BYTE) begin
        next_order_byte = link.prm_data;
      end
    end
    if (link.prm_end) begin
      // Judge byte ten, including a byte that arrives with the end strobe.
      next_prm_ack = 1'b1;
      if (next_order_byte[1:0] == `FSIO_ORDER_BIG) begin
        next_le = 1'b0;
        next_prm_fault = 1'b0;
        next_state = SLV_WAIT_CFG;
      end else if (next_order_byte[1:0] == `FSIO_ORDER_LITTLE) begin
        next_le = 1'b1;
        next_prm_fault = 1'b0;
        next_state = SLV_WAIT_CFG;
      end else begin
        // Default zero and the both-set value are refused alike.
        next_prm_fault = 1'b1;
        next_state = SLV_FAULT;
      end
    end else begin
      case (state)
        SLV_WAIT_CFG: begin
          if (link.cfg_valid) begin
            next_state = SLV_EXCHANGE;
          end
        end
        SLV_EXCHANGE: begin
          // Exchange requests are ignored in every other phase.
          if (link.dx_req) begin
            next_dx_ack = 1'b1;
            next_cw1 = in_cw1;
            next_cw2 = in_cw2;
            next_weld = in_cw1[`FSIO_WELD_BIT] & ~cw1[`FSIO_WELD_BIT];
            next_horn = in_cw1[`FSIO_HORN_BIT] & ~cw1[`FSIO_HORN_BIT];
            // A changed request opens a new handshake; the answer slot reads no instruction meanwhile.
            if ((in_id != req_id) || (in_idx != req_idx) || (in_val != req_val)) begin
              next_req_id = in_id;
              next_req_idx = in_idx;
              next_req_val = in_val;
              next_ans_code = `FSIO_CODE_NONE;
              next_req_valid = (in_id[`FSIO_CODE_MSB -: 4] != `FSIO_CODE_NONE);
            end
            // The input image is built from one snapshot so every region is consistent.
            next_dx_in = {fsio_order16({next_ans_code, next_req_id[`FSIO_NUM_MSB:0]}, le),
                          fsio_order16(next_req_idx, le),
                          fsio_order32(next_ans_val, le),
                          fsio_order16(status_word_one_i, le),
                          fsio_order16(status_word_two_i, le)};
          end
        end
        default: begin
          next_state = state;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.

  // Until a good block arrives the order is big and the image reads zero.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= SLV_WAIT_PRM;
      order_byte <= 8'h00;
      le <= 1'b0;
      prm_ack <= 1'b0;
      prm_fault <= 1'b0;
      dx_ack <= 1'b0;
      dx_in <= 96'h0;
      cw1 <= 16'h0000;
      cw2 <= 16'h0000;
      weld <= 1'b0;
      horn <= 1'b0;
      req_valid <= 1'b0;
      req_id <= 16'h0000;
      req_idx <= 16'h0000;
      req_val <= 32'h0000_0000;
      ans_code <= 4'h0;
      ans_val <= 32'h0000_0000;
    end else begin
      state <= next_state;
      order_byte <= next_order_byte;
      le <= next_le;
      prm_ack <= next_prm_ack;
      prm_fault <= next_prm_fault;
      dx_ack <= next_dx_ack;
      dx_in <= next_dx_in;
      cw1 <= next_cw1;
      cw2 <= next_cw2;
      weld <= next_weld;
      horn <= next_horn;
      req_valid <= next_req_valid;
      req_id <= next_req_id;
      req_idx <= next_req_idx;
      req_val <= next_req_val;
      ans_code <= next_ans_code;
      ans_val <= next_ans_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign link.prm_ack = prm_ack;
  assign link.prm_fault = prm_fault;
  assign link.dx_ack = dx_ack;
  assign link.dx_in = dx_in;
  assign control_word_one_o = cw1;
  assign control_word_two_o = cw2;
  assign parset_sel_o = cw1[`FSIO_PARSET_MSB:0];
  assign weld_trigger_o = weld;
  assign horn_trigger_o = horn;
  assign req_valid_o = req_valid;
  assign req_code_o = req_id[`FSIO_CODE_MSB -: 4];
  assign req_number_o = req_id[`FSIO_NUM_MSB:0];
  assign req_index_o = req_idx;
  assign req_value_o = req_val;
  assign exchange_active_o = (state == SLV_EXCHANGE);
  assign prm_error_o = prm_fault;
  assign little_endian_o = le;
endmodule
